//--- rx_qual_cfg.svh
// Register offsets, field positions and reset values for the frame qualifier
`ifndef RX_QUAL_CFG_SVH
`define RX_QUAL_CFG_SVH
`define PORT_SELECT_ADDR 8'h4C
`define PORT_FRAME_CONFIG_ADDR 8'h7C
`define PORT_QUALIFY_CONTROL_ADDR 8'h7D
`define PORT_FRAME_CONFIG_RESET 8'h20
`define PORT_QUALIFY_CONTROL_RESET 8'h00
`define PORT_SELECT_RESET 8'h01
`define FC_REDUCE_HI 7
`define FC_REDUCE_LO 6
`define FC_TRUNC_PARITY 5
`define FC_TRUNC_ROW_SIZE 4
`define FC_TRUNC_PIC_SIZE 3
`define FC_ROW_POLARITY 1
`define FC_PIC_POLARITY 0
`define QC_DISCARD_EN 7
`define QC_CHECK_ROW_COUNT 5
`define QC_CHECK_ROW_SIZE 4
`define QC_PARITY_STICKY 3
`define QC_WATCHDOG_DISABLE 2
`define QC_THRESH_HI 1
`define QC_THRESH_LO 0
`define COUNT_WIDTH 16
`endif

//--- rx_qual_pkg.sv
// Types shared by the frame qualifier files
package rx_qual_pkg;
    typedef enum logic [1:0] {
        reduce_normal = 2'b00,
        reduce_reserved = 2'b01,
        reduce_upper = 2'b10,
        reduce_lower = 2'b11
    } reduce_mode_e;
endpackage

//--- rx_qual_port.sv
// One receive port: marker polarity, size checks, truncation and qualification
`timescale 1ns/1ps
`include "rx_qual_cfg.svh"
module rx_qual_port
    import rx_qual_pkg::*;
#(
    parameter int CW = `COUNT_WIDTH
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] frame_config,
    input wire logic [7:0] qualify_control,
    input wire logic lock,
    input wire logic row_active_flag,
    input wire logic picture_active_flag,
    input wire logic in_valid,
    input wire logic [9:0] in_data,
    input wire logic parity_err,
    output logic out_valid,
    output logic [9:0] out_data,
    output logic out_eof,
    output logic qualified
);
    // Normalise markers to active high
    wire logic row_on = row_active_flag ^ frame_config[`FC_ROW_POLARITY];
    wire logic pic_on = picture_active_flag ^ frame_config[`FC_PIC_POLARITY];
    logic row_d;
    logic pic_d;
    logic [CW-1:0] row_len;
    logic [CW-1:0] row_ref;
    logic [CW-1:0] row_cnt;
    logic [CW-1:0] rows_ref;
    logic row_ref_ok;
    logic rows_ref_ok;
    logic [1:0] good_cnt;
    logic [CW:0] frame_len;
    logic [CW:0] period;
    logic [CW+1:0] wd_cnt;
    logic dropping;
    logic viol;
    wire logic row_end = row_d && !row_on;
    wire logic pic_start = pic_on && !pic_d;
    wire logic pic_end = pic_d && !pic_on;
    wire logic size_chg = row_end && row_ref_ok && (row_len != row_ref);
    wire logic count_chg = pic_end && rows_ref_ok && (row_cnt + CW'(row_end) != rows_ref);
    wire logic [1:0] thresh = qualify_control[`QC_THRESH_HI:`QC_THRESH_LO];
    wire logic trunc_par = frame_config[`FC_TRUNC_PARITY] && parity_err;
    wire logic trunc_size = frame_config[`FC_TRUNC_ROW_SIZE] && size_chg;
    wire logic trunc_cnt = frame_config[`FC_TRUNC_PIC_SIZE] && count_chg;
    wire logic q_par = qualify_control[`QC_PARITY_STICKY] ? 1'b0 : parity_err;
    wire logic q_hard = (qualify_control[`QC_CHECK_ROW_COUNT] && count_chg)
        || (qualify_control[`QC_CHECK_ROW_SIZE] && size_chg)
        || (qualify_control[`QC_PARITY_STICKY] && parity_err);
    // A frame counts as good only if no enabled check fired during it
    wire logic frame_bad = viol || q_hard || trunc_par || trunc_size || trunc_cnt;
    wire logic frame_good = pic_end && !frame_bad;
    wire logic wd_fire = !qualify_control[`QC_WATCHDOG_DISABLE] && thresh != 2'b00
        && period != '0 && wd_cnt > {period, 1'b0};
    wire logic next_qual_base = thresh == 2'b00 ? lock
        : (good_cnt >= thresh && lock);
    wire logic pass_now = qualified && !q_par;
    wire logic gate_ok = !qualify_control[`QC_DISCARD_EN] || pass_now;
    wire logic trunc_now = trunc_par || trunc_size || trunc_cnt;
    wire logic [9:0] reduced =
        frame_config[`FC_REDUCE_HI:`FC_REDUCE_LO] == reduce_upper ? {2'b00, in_data[9:2]}
        : frame_config[`FC_REDUCE_HI:`FC_REDUCE_LO] == reduce_lower ? {2'b00, in_data[7:0]}
        : in_data;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            row_d <= 1'b0;
            pic_d <= 1'b0;
            row_len <= '0;
            row_ref <= '0;
            row_cnt <= '0;
            rows_ref <= '0;
            row_ref_ok <= 1'b0;
            rows_ref_ok <= 1'b0;
        end
        else
        begin
            row_d <= row_on;
            pic_d <= pic_on;
            row_len <= row_on ? (in_valid ? row_len + 1'b1 : row_len) : '0;
            if (row_end)
            begin
                row_ref <= row_len;
                row_ref_ok <= 1'b1;
            end
            if (pic_start)
                row_cnt <= '0;
            else if (row_end)
                row_cnt <= row_cnt + 1'b1;
            if (pic_end)
            begin
                rows_ref <= row_cnt + CW'(row_end);
                rows_ref_ok <= 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            good_cnt <= 2'b00;
            viol <= 1'b0;
            qualified <= 1'b0;
            frame_len <= '0;
            period <= '0;
            wd_cnt <= '0;
        end
        else
        begin
            // A violation in the start cycle still marks the new frame
            viol <= (viol && !pic_start) || trunc_now || q_hard;
            frame_len <= pic_start ? '0 : frame_len + 1'b1;
            if (pic_start && frame_len != '0)
                period <= frame_len;
            wd_cnt <= frame_good ? '0 : (wd_fire ? wd_cnt : wd_cnt + 1'b1);
            if (!lock || q_hard || wd_fire)
                good_cnt <= 2'b00;
            else if (frame_good && good_cnt != 2'b11)
                good_cnt <= good_cnt + 1'b1;
            qualified <= next_qual_base && !q_hard && !wd_fire && !q_par;
        end
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dropping <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 10'h000;
            out_eof <= 1'b0;
        end
        else
        begin
            // Drop the rest of a truncated frame; reopen at the next frame start
            if (trunc_now)
                dropping <= 1'b1;
            else if (pic_start && gate_ok)
                dropping <= 1'b0;
            out_valid <= in_valid && pic_on && !dropping && !trunc_now && gate_ok;
            out_data <= reduced;
            out_eof <= (trunc_now && !dropping) || (pic_end && !dropping);
        end
    end
    a_trunc_drops: assert property (@(posedge ref_clk) disable iff (rst)
        trunc_now |=> !out_valid)
        else $error("data forwarded in truncating cycle");
    a_qual_needs_lock: assert property (@(posedge ref_clk) disable iff (rst)
        !lock |=> !qualified)
        else $error("qualified without lock");
    a_discard_gate: assert property (@(posedge ref_clk) disable iff (rst)
        qualify_control[`QC_DISCARD_EN] && !qualified |=> !out_valid)
        else $error("data forwarded while not qualified");
    a_parity_clears: assert property (@(posedge ref_clk) disable iff (rst)
        parity_err |=> !qualified)
        else $error("qualified after parity error");
    a_size_clears: assert property (@(posedge ref_clk) disable iff (rst)
        qualify_control[`QC_CHECK_ROW_SIZE] && size_chg |=> !qualified)
        else $error("qualified after row size change");
    a_count_clears: assert property (@(posedge ref_clk) disable iff (rst)
        qualify_control[`QC_CHECK_ROW_COUNT] && count_chg && thresh != 2'b00
        |=> !qualified ##1 !qualified)
        else $error("qualified after row count change");
    a_zero_thresh: assert property (@(posedge ref_clk) disable iff (rst)
        thresh == 2'b00 && lock && !parity_err && !q_hard |=> qualified)
        else $error("zero threshold did not qualify on lock");
    a_truncated_holds: assert property (@(posedge ref_clk) disable iff (rst)
        trunc_par && !pic_start |=> dropping)
        else $error("parity truncation not held");
    c_qualify: cover property (@(posedge ref_clk) disable iff (rst) $rose(qualified));
    c_truncate: cover property (@(posedge ref_clk) disable iff (rst) trunc_now);
    c_watchdog: cover property (@(posedge ref_clk) disable iff (rst) wd_fire);
    c_good_frame: cover property (@(posedge ref_clk) disable iff (rst) frame_good);
endmodule

//--- rx_frame_qualifier.sv
// Two-port frame qualifier with port-selected register page
`timescale 1ns/1ps
`include "rx_qual_cfg.svh"
// How it works
// - Bits 7:6 choose Raw10 handling: normal, reserved, upper eight, lower eight.
// - Parity-truncate bit set cuts the frame on parity error, else forwards.
// - Row-size-truncate bit set cuts the frame when row length changes.
// - Frame-size-truncate bit cuts on row-count change; resume at the next frame start.
// - Bit 1 inverts the expected row marker polarity in raw mode.
// - Bit 0 inverts the expected picture marker polarity in raw mode.
// - Discard enable drops data while not qualified; otherwise qualification ignored.
// - Row-count checking drops qualification on count change until threshold met.
// - Row-size checking drops qualification on size change until threshold met.
// - Parity mode 0 drops qualification per error; mode 1 holds until threshold.
// - Unless disabled, no good frame end within two periods drops qualification.
// - Watchdog has no effect while the threshold is zero.
// - Threshold zero qualifies on lock; else after that many good frames.
// - Each port has its own registers, reached through the port select register.
module rx_frame_qualifier
    import rx_qual_pkg::*;
#(
    parameter int PORTS = 2
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [PORTS-1:0] lock_pin,
    input wire logic [PORTS-1:0] row_active_flag,
    input wire logic [PORTS-1:0] picture_active_flag,
    input wire logic [PORTS-1:0] in_valid,
    input wire logic [PORTS*10-1:0] in_data,
    input wire logic [PORTS-1:0] parity_err,
    output logic [PORTS-1:0] out_valid,
    output logic [PORTS*10-1:0] out_data,
    output logic [PORTS-1:0] out_eof,
    output logic [PORTS-1:0] qualified
);
    logic [7:0] port_select;
    logic [7:0] frame_config [PORTS];
    logic [7:0] qualify_control [PORTS];
    // Lock comes from the link side, so it is synchronised first
    logic [PORTS-1:0] lock_s1;
    logic [PORTS-1:0] lock_s2;
    wire logic hit_sel = reg_addr == `PORT_SELECT_ADDR;
    wire logic hit_fc = reg_addr == `PORT_FRAME_CONFIG_ADDR;
    wire logic hit_qc = reg_addr == `PORT_QUALIFY_CONTROL_ADDR;
    // Reads come from the lowest selected port when several are selected
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit_sel)
            next_rdata = port_select;
        for (int p = PORTS - 1; p >= 0; p--)
        begin
            if (port_select[p] && hit_fc)
                next_rdata = frame_config[p];
            if (port_select[p] && hit_qc)
                next_rdata = qualify_control[p];
        end
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            lock_s1 <= '0;
            lock_s2 <= '0;
            reg_rdata <= 8'h00;
            port_select <= `PORT_SELECT_RESET;
        end
        else
        begin
            lock_s1 <= lock_pin;
            lock_s2 <= lock_s1;
            if (reg_rd)
                reg_rdata <= next_rdata;
            if (reg_wr && hit_sel)
                port_select <= reg_wdata;
        end
    end
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                frame_config[p] <= `PORT_FRAME_CONFIG_RESET;
                qualify_control[p] <= `PORT_QUALIFY_CONTROL_RESET;
            end
            else if (reg_wr && port_select[p])
            begin
                // Writes with several ports selected reach every selected copy
                if (hit_fc)
                    frame_config[p] <= reg_wdata;
                if (hit_qc)
                    qualify_control[p] <= reg_wdata;
            end
        end
        rx_qual_port u_port (
            .ref_clk(ref_clk),
            .rst(rst),
            .frame_config(frame_config[p]),
            .qualify_control(qualify_control[p]),
            .lock(lock_s2[p]),
            .row_active_flag(row_active_flag[p]),
            .picture_active_flag(picture_active_flag[p]),
            .in_valid(in_valid[p]),
            .in_data(in_data[p*10 +: 10]),
            .parity_err(parity_err[p]),
            .out_valid(out_valid[p]),
            .out_data(out_data[p*10 +: 10]),
            .out_eof(out_eof[p]),
            .qualified(qualified[p])
        );
        a_write_reaches: assert property (@(posedge ref_clk) disable iff (rst)
            reg_wr && hit_fc && port_select[p] |=> frame_config[p] == $past(reg_wdata))
            else $error("frame config write lost");
        a_write_isolated: assert property (@(posedge ref_clk) disable iff (rst)
            reg_wr && hit_qc && !port_select[p] |=> $stable(qualify_control[p]))
            else $error("unselected port written");
    end
    c_read_page: cover property (@(posedge ref_clk) disable iff (rst)
        reg_rd && hit_fc && port_select == 8'h02);
endmodule

//--- remote_video_source.sv
// Behavioural remote serializer driving the raw video pins of one receive port
`timescale 1ns/1ps
module remote_video_source (
    input wire logic ref_clk,
    input wire logic [9:0] word,
    output logic row_active_flag,
    output logic picture_active_flag,
    output logic in_valid,
    output logic [9:0] in_data,
    output logic parity_err
);
    initial
    begin
        row_active_flag = 1'b0;
        picture_active_flag = 1'b0;
        in_valid = 1'b0;
        in_data = 10'h000;
        parity_err = 1'b0;
    end
    // Idle data flips every cycle so a stale word never passes for a real one
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            in_valid = 1'b0;
            parity_err = 1'b0;
            in_data = ~in_data;
        end
    endtask
    // Error cycle is an extra gap, so row length stays as asked
    task automatic frame(input int rows, input int cols, input int err_col,
        input logic rp, input logic pp);
        picture_active_flag = ~pp;
        row_active_flag = rp;
        idle(2);
        for (int r = 0; r < rows; r++)
        begin
            for (int c = 0; c < cols; c++)
            begin
                if (r == 0 && c == err_col)
                begin
                    @(negedge ref_clk);
                    in_valid = 1'b0;
                    parity_err = 1'b1;
                end
                @(negedge ref_clk);
                row_active_flag = ~rp;
                parity_err = 1'b0;
                in_valid = 1'b1;
                in_data = word;
            end
            @(negedge ref_clk);
            row_active_flag = rp;
            in_valid = 1'b0;
            idle(2);
        end
        picture_active_flag = pp;
        idle(3);
    endtask
endmodule

//--- test_rx_frame_qualifier.sv
// Self-checking bench for the two-port frame qualifier
`timescale 1ns/1ps
`include "rx_qual_cfg.svh"
module test_rx_frame_qualifier import rx_qual_pkg::*; ;
    logic ref_clk, rst, reg_wr, reg_rd, rd_seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sel;
    logic [1:0] lock_pin, row_active_flag, picture_active_flag, in_valid, parity_err;
    logic [1:0] out_valid, out_eof, qualified;
    logic [19:0] in_data, out_data;
    logic [9:0] rnd_word = 10'h000;
    logic [31:0] seed = 32'h00004666;
    logic [7:0] cfg [2];
    logic [19:0] exp_q [2][$];
    logic [7:0] rd_q [$];
    int keep [2], cnt [2], eof_cnt [2];
    int err_total, num_checks, cycles;
    logic [19:0] note;
    rx_frame_qualifier #(.PORTS(2)) rx_frame_qualifier_inst (.ref_clk(ref_clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .lock_pin(lock_pin), .row_active_flag(row_active_flag),
        .picture_active_flag(picture_active_flag), .in_valid(in_valid), .in_data(in_data),
        .parity_err(parity_err), .out_valid(out_valid), .out_data(out_data),
        .out_eof(out_eof), .qualified(qualified));
    for (genvar p = 0; p < 2; p++)
    begin : src
        remote_video_source remote_video_source_inst (.ref_clk(ref_clk), .word(rnd_word),
            .row_active_flag(row_active_flag[p]), .picture_active_flag(picture_active_flag[p]),
            .in_valid(in_valid[p]), .in_data(in_data[p*10+:10]), .parity_err(parity_err[p]));
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Upper half of a note is the mask of bits that the mode defines
    function automatic logic [19:0] expect_word(input logic [7:0] c, input logic [9:0] d);
        case (reduce_mode_e'(c[7:6]))
            reduce_upper: return {10'h0FF, 2'h0, d[9:2]};
            reduce_lower: return {10'h0FF, 2'h0, d[7:0]};
            default: return {10'h3FF, d};
        endcase
    endfunction
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        if (a == `PORT_SELECT_ADDR)
            sel = d;
        for (int p = 0; p < 2; p++)
            if (a == `PORT_FRAME_CONFIG_ADDR && sel[p])
                cfg[p] = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        rd_q.push_back(e);
        @(negedge ref_clk);
        reg_rd = 1'b0;
    endtask
    // Only the first kept words of a frame are expected at the output
    task automatic send(input int p, input int rows, input int cols, input int errc, input int kept);
        keep[p] = kept;
        cnt[p] = 0;
        if (p == 0)
            src[0].remote_video_source_inst.frame(rows, cols, errc, cfg[0][1], cfg[0][0]);
        else
            src[1].remote_video_source_inst.frame(rows, cols, errc, cfg[1][1], cfg[1][0]);
    endtask
    task automatic qchk(input logic e, input int wait_n);
        repeat (wait_n) @(negedge ref_clk);
        check(qualified[0], e);
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        seed <= xorshift(seed);
        rnd_word <= seed[9:0];
        cycles++;
        if (cycles == 10000)
        begin
            err_total++;
            give_verdict();
        end
    end
    always @(posedge ref_clk)
        for (int p = 0; p < 2; p++)
            if (in_valid[p] === 1'b1)
            begin
                if (cnt[p] < keep[p])
                    exp_q[p].push_back(expect_word(cfg[p], in_data[p*10+:10]));
                cnt[p]++;
            end
    always @(posedge ref_clk)
    begin
        rd_seen <= reg_rd;
        if (rd_seen === 1'b1)
            check(reg_rdata, rd_q.pop_front());
        for (int p = 0; p < 2; p++)
        begin
            if (out_eof[p] === 1'b1)
                eof_cnt[p]++;
            if (out_valid[p] === 1'b1 && exp_q[p].size() == 0)
                check(20'h00000, 20'h00001);
            else if (out_valid[p] === 1'b1)
            begin
                note = exp_q[p].pop_front();
                check(out_data[p*10+:10] & note[19:10], note & 20'h003FF);
            end
        end
    end
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        lock_pin = 2'h0;
        sel = 8'h01;
        cfg = '{8'h20, 8'h20};
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rd(`PORT_SELECT_ADDR, 8'h01);
        rd(`PORT_FRAME_CONFIG_ADDR, 8'h20);
        rd(`PORT_QUALIFY_CONTROL_ADDR, 8'h00);
        rd(8'h50, 8'h00);
        wr(`PORT_SELECT_ADDR, 8'h02);
        wr(`PORT_FRAME_CONFIG_ADDR, 8'hC0);
        rd(`PORT_FRAME_CONFIG_ADDR, 8'hC0);
        wr(`PORT_SELECT_ADDR, 8'h01);
        rd(`PORT_FRAME_CONFIG_ADDR, 8'h20);
        lock_pin = 2'h3;
        repeat (5) @(negedge ref_clk);
        check(qualified, 20'h00003);
        for (int m = 0; m < 4; m++)
            if (m != 1)
            begin
                wr(`PORT_FRAME_CONFIG_ADDR, {m[1:0], 6'h00});
                fork
                    send(0, 2, 4, -1, 8);
                    send(1, 2, 3, -1, 6);
                join
            end
        check(20'(eof_cnt[0]), 20'h00003);
        check(20'(eof_cnt[1]), 20'h00003);
        // Watchdog off here so only the threshold gates requalification
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'h0E);
        send(0, 2, 4, 2, 8);
        qchk(1'b0, 4);
        send(0, 2, 4, -1, 8);
        qchk(1'b0, 4);
        send(0, 2, 4, -1, 8);
        qchk(1'b1, 4);
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'hA6);
        send(0, 1, 4, -1, 4);
        qchk(1'b0, 4);
        send(0, 1, 4, -1, 0);
        send(0, 1, 4, -1, 0);
        qchk(1'b1, 4);
        send(0, 1, 4, -1, 4);
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'h16);
        send(0, 1, 3, -1, 3);
        qchk(1'b0, 4);
        wr(`PORT_FRAME_CONFIG_ADDR, 8'hD0);
        send(0, 2, 2, -1, 2);
        send(0, 2, 2, -1, 4);
        wr(`PORT_FRAME_CONFIG_ADDR, 8'hC8);
        send(0, 1, 2, -1, 2);
        send(0, 2, 2, -1, 4);
        wr(`PORT_FRAME_CONFIG_ADDR, 8'h00);
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'h01);
        send(0, 2, 4, -1, 8);
        send(0, 2, 4, -1, 8);
        qchk(1'b1, 4);
        qchk(1'b0, 200);
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'h00);
        qchk(1'b1, 200);
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'h05);
        send(0, 2, 4, -1, 8);
        send(0, 2, 4, -1, 8);
        qchk(1'b1, 200);
        wr(`PORT_QUALIFY_CONTROL_ADDR, 8'h00);
        wr(`PORT_FRAME_CONFIG_ADDR, 8'h23);
        send(0, 2, 4, 2, 2);
        send(0, 2, 4, -1, 8);
        repeat (5) @(negedge ref_clk);
        check(20'(exp_q[0].size()), 20'h00000);
        check(20'(exp_q[1].size()), 20'h00000);
        check(20'(eof_cnt[0]), 20'h00015);
        give_verdict();
    end
endmodule
